// ### inc/async_serial_defs.svh
// offsets, field positions, reset values and counts of the serial unit
// assumes a 16-bit register port with byte offsets on a 4-bit address
`ifndef ASYNC_SERIAL_DEFS_SVH
`define ASYNC_SERIAL_DEFS_SVH
// ************
// offsets
// ************
`define BAUD_OFS 4'h8
`define CTRL_OFS 4'hA
`define STAT_OFS 4'hC
`define DATA_OFS 4'hE
// ************
// control fields
// ************
`define LOOP_BIT 14
`define ODRN_BIT 13
`define ILT_BIT 12
`define PODD_BIT 11
`define PON_BIT 10
`define WIDE_BIT 9
`define WAKE_BIT 8
`define TIE_BIT 7
`define TX_DONE_IRQ_ENABLE_BIT 6
`define RIE_BIT 5
`define IDLE_IRQ_ENABLE_BIT 4
`define TXON_BIT 3
`define RXON_BIT 2
`define SLEEP_BIT 1
`define BRK_BIT 0
// ************
// status fields
// ************
`define TX_HOLDING_EMPTY_BIT 8
`define TC_BIT 7
`define RX_HOLDING_FULL_BIT 6
`define RAF_BIT 5
`define IDLE_BIT 4
`define OR_BIT 3
`define NF_BIT 2
`define FE_BIT 1
`define PF_BIT 0
`define RX_FLAG_MASK 9'h05F
`define TX_FLAG_MASK 9'h180
// ************
// reset values and counts
// ************
`define FLAG_RST 9'h180
`define CTRL_RST 15'h0000
`define DIV_RST 13'h0000
`define SMP_A 4'h7
`define SMP_B 4'h8
`define SMP_C 4'h9
`define RESYNC_PH 4'h1
`define FRAME_NARROW 4'hA
`define FRAME_WIDE 4'hB
`endif

// ### inc/async_serial_pkg.sv
// types shared by the serial unit and its baud generator
// assumes nothing beyond the compile order
package async_serial_pkg;
    typedef logic [3:0] addr_type;
    typedef logic [15:0] word_type;
    typedef enum logic {RX_IDLE, RX_BITS} rx_state_type;
endpackage : async_serial_pkg

// ### inc/baud_if.sv
// divisor and tick strobes between the unit and its baud generator
// assumes both ends run on the same clock
interface baud_if #(parameter int DIV_W = 13);
    logic [DIV_W-1:0] divisor;
    logic sample_tick;
    logic bit_tick;
    modport gen(input divisor, output sample_tick, output bit_tick);
    modport user(output divisor, input sample_tick, input bit_tick);
endinterface : baud_if

// ### logic/async_serial_interface.sv
// serial unit: register port, transmitter, receiver, pin control
// assumes a one-cycle strobe register port and an unsynchronised receive pin
// ************
// What this block does
// - bit rate is clock over 32 times the 13-bit divisor, 1..8191
// - divisor zero stops the baud generator completely
// - receiver samples at sixteen times the bit rate
// - receiver realigns sampling points on line transitions
// - loopback feeds transmitter into receiver, pin held at mark while transmitter on or mid-frame
// - open drain select makes the driven pin open drain
// - idle count starts on any one, or after stop bit
// - parity on for both directions, odd select picks odd
// - with parity, top data bit carries parity
// - eight or nine data bits, frames of 10 or 11 bits
// - wrong received parity sets parity error flag
// - sleep ignores data; idle or marked character wakes the receiver
// - interrupt when an enabled flag among four is set
// - transmitter keeps the pin until the stop bit of the current character begins
// - receiver off sets no receive flags and clears RAF
// - break sends zero frames after the current frame
// - status read then data read clears the receive flags seen, data write the transmit flags seen
// - flag set after the status read survives the data access
// - any status read arms all set flags
// - holding empty set on transfer; unacknowledged writes are not sent
// - transmit complete set when all queued frames are out
// - holding full and error flags set in one cycle
// - overrun keeps old data and drops characters until cleared
// - three samples per bit, majority taken, disagreement flags noise
// - zero at stop bit sets framing flag
// - idle flag rearms only after a received character
// ************
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "async_serial_defs.svh"
module async_serial_interface #(parameter int DIV_W = 13) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input async_serial_pkg::addr_type I_ADDR,
    input async_serial_pkg::word_type I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output async_serial_pkg::word_type O_RDATA,
    input wire logic I_RXD,
    input wire logic I_GPIO_DIR,
    input wire logic I_GPIO_OUT,
    output logic O_TXD,
    output logic O_TXD_OE,
    output logic O_IRQ
);
    import async_serial_pkg::*;

    function automatic logic par_bit(input logic [8:0] d, input logic wide, input logic odd);
        par_bit = (wide ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction : par_bit

    function automatic logic [3:0] frame_len(input logic wide);
        frame_len = wide ? `FRAME_WIDE : `FRAME_NARROW;
    endfunction : frame_len

    logic [DIV_W-1:0] divisor_ff;
    logic [14:0] ctrl_ff;
    logic [8:0] flag_ff, arm_ff, clr, tx_ev_ff, rx_ev_ff;
    logic tc_clr_ff, wake_ev_ff, raf_ff;
    logic [8:0] tdr_ff, rdr_ff;
    word_type rdata_ff;
    logic loop, wide, pon, podd, tx_on, rx_on, sleep, brk;
    logic rd_data, wr_data;

    assign loop = ctrl_ff[`LOOP_BIT];
    assign wide = ctrl_ff[`WIDE_BIT];
    assign pon = ctrl_ff[`PON_BIT];
    assign podd = ctrl_ff[`PODD_BIT];
    assign tx_on = ctrl_ff[`TXON_BIT];
    assign rx_on = ctrl_ff[`RXON_BIT];
    assign sleep = ctrl_ff[`SLEEP_BIT];
    assign brk = ctrl_ff[`BRK_BIT];
    assign rd_data = I_RD && (I_ADDR == `DATA_OFS);
    assign wr_data = I_WR && (I_ADDR == `DATA_OFS);
    assign O_RDATA = rdata_ff;

    // ************
    // baud generator
    // ************
    baud_if #(.DIV_W(DIV_W)) bif();
    assign bif.divisor = divisor_ff;
    baud_gen #(.DIV_W(DIV_W)) u_baud (.i_clk(I_CLK), .i_resetn(I_RESETN), .bus(bif));

    // ************
    // receive pin synchroniser
    // ************
    logic [2:0] rx_sync_ff;
    logic rx_pin_ff;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rx_sync_ff <= 3'h7;
            rx_pin_ff <= 1'b1;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], I_RXD};
            if (rx_sync_ff[1] == rx_sync_ff[2]) begin
                rx_pin_ff <= rx_sync_ff[2];
            end
        end
    end

    // ************
    // configuration registers
    // ************
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            divisor_ff <= `DIV_RST;
            ctrl_ff <= `CTRL_RST;
        end else begin
            if (I_WR && (I_ADDR == `BAUD_OFS)) begin
                divisor_ff <= I_WDATA[DIV_W-1:0];
            end
            if (I_WR && (I_ADDR == `CTRL_OFS)) begin
                ctrl_ff <= I_WDATA[14:0];
            end else if (wake_ev_ff) begin
                ctrl_ff[`SLEEP_BIT] <= 1'b0;
            end
        end
    end

    // ************
    // status flags and acknowledge sequence
    // ************
    always_comb begin
        clr = 9'h000;
        if (rd_data) begin
            clr = arm_ff & `RX_FLAG_MASK;
        end else if (wr_data) begin
            clr = arm_ff & `TX_FLAG_MASK;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            flag_ff <= `FLAG_RST;
            arm_ff <= 9'h000;
        end else begin
            flag_ff <= (flag_ff & ~clr & ~{1'b0, tc_clr_ff, 7'h00}) | tx_ev_ff | rx_ev_ff;
            if (I_RD && (I_ADDR == `STAT_OFS)) begin
                arm_ff <= flag_ff & ~(tx_ev_ff | rx_ev_ff);
            end else begin
                arm_ff <= arm_ff & ~clr & ~(tx_ev_ff | rx_ev_ff);
            end
        end
    end

    // ************
    // read data and interrupt
    // ************
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_ff <= 16'h0000;
            O_IRQ <= 1'b0;
        end else begin
            rdata_ff <= 16'h0000;
            if (I_RD) begin
                if (I_ADDR == `BAUD_OFS) begin
                    rdata_ff <= 16'(divisor_ff);
                end else if (I_ADDR == `CTRL_OFS) begin
                    rdata_ff <= {1'b0, ctrl_ff};
                end else if (I_ADDR == `STAT_OFS) begin
                    rdata_ff <= {7'h00, flag_ff | {3'h0, raf_ff, 5'h00}};
                end else if (I_ADDR == `DATA_OFS) begin
                    rdata_ff <= {7'h00, rdr_ff};
                end
            end
            O_IRQ <= (flag_ff[`TX_HOLDING_EMPTY_BIT] & ctrl_ff[`TIE_BIT])
                | (flag_ff[`TC_BIT] & ctrl_ff[`TX_DONE_IRQ_ENABLE_BIT])
                | (flag_ff[`RX_HOLDING_FULL_BIT] & ctrl_ff[`RIE_BIT])
                | (flag_ff[`IDLE_BIT] & ctrl_ff[`IDLE_IRQ_ENABLE_BIT]);
        end
    end

    // ************
    // transmitter
    // ************
    logic [10:0] tx_shift_ff, nxt_frame;
    logic [3:0] tx_cnt_ff;
    logic tx_line_ff, tx_on_d_ff, pre_ff, tx_act_ff;
    logic load_brk, load_pre, load_dat;
    logic [8:0] tx_field;

    always_comb begin
        load_brk = tx_on && brk;
        load_pre = tx_on && !brk && pre_ff;
        load_dat = tx_on && !brk && !pre_ff && !flag_ff[`TX_HOLDING_EMPTY_BIT];
        tx_field = tdr_ff;
        if (pon && wide) begin
            tx_field[8] = par_bit(tdr_ff, 1'b1, podd);
        end else if (pon) begin
            tx_field[7] = par_bit(tdr_ff, 1'b0, podd);
        end
        if (load_brk) begin
            nxt_frame = 11'h000;
        end else if (load_pre) begin
            nxt_frame = 11'h7FF;
        end else if (wide) begin
            nxt_frame = {1'b1, tx_field, 1'b0};
        end else begin
            nxt_frame = {2'b11, tx_field[7:0], 1'b0};
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tdr_ff <= 9'h000;
        end else if (wr_data) begin
            tdr_ff <= I_WDATA[8:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tx_shift_ff <= 11'h7FF;
            tx_cnt_ff <= 4'h0;
            tx_line_ff <= 1'b1;
            tx_on_d_ff <= 1'b0;
            pre_ff <= 1'b0;
            tx_act_ff <= 1'b0;
            tx_ev_ff <= 9'h000;
            tc_clr_ff <= 1'b0;
        end else begin
            tx_ev_ff <= 9'h000;
            tc_clr_ff <= 1'b0;
            tx_on_d_ff <= tx_on;
            if (tx_on && !tx_on_d_ff) begin
                pre_ff <= 1'b1;
            end
            if (bif.bit_tick) begin
                if (tx_cnt_ff != 4'h0) begin
                    tx_line_ff <= tx_shift_ff[0];
                    tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                    tx_cnt_ff <= tx_cnt_ff - 4'h1;
                end else if (load_brk || load_pre || load_dat) begin
                    tx_line_ff <= nxt_frame[0];
                    tx_shift_ff <= {1'b1, nxt_frame[10:1]};
                    tx_cnt_ff <= frame_len(wide) - 4'h1;
                    tx_act_ff <= 1'b1;
                    tc_clr_ff <= 1'b1;
                    if (load_pre) begin
                        pre_ff <= 1'b0;
                    end
                    if (load_dat) begin
                        tx_ev_ff[`TX_HOLDING_EMPTY_BIT] <= 1'b1;
                    end
                end else begin
                    tx_line_ff <= 1'b1;
                    tx_act_ff <= 1'b0;
                    if (tx_act_ff) begin
                        tx_ev_ff[`TC_BIT] <= 1'b1;
                    end
                end
            end
        end
    end

    // ************
    // transmit pin
    // ************
    logic pin_own, pin_val;
    always_comb begin
        pin_own = tx_on || (tx_cnt_ff != 4'h0);
        if (pin_own) begin
            pin_val = loop ? 1'b1 : tx_line_ff;
        end else begin
            pin_val = I_GPIO_OUT;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_TXD <= 1'b1;
            O_TXD_OE <= 1'b0;
        end else begin
            O_TXD <= pin_val;
            O_TXD_OE <= (pin_own || I_GPIO_DIR) && (!ctrl_ff[`ODRN_BIT] || !pin_val);
        end
    end

    // ************
    // receiver
    // ************
    rx_state_type rx_state_ff;
    logic [3:0] phase_ff, idx_ff;
    logic [1:0] smp_ff;
    logic prev_ff, noise_ff, idle_arm_ff;
    logic [8:0] rx_data_ff;
    logic [7:0] idle_cnt_ff, idle_lim;
    logic rx_in, maj, noisy, msb, perr;

    always_comb begin
        rx_in = loop ? tx_line_ff : rx_pin_ff;
        maj = (smp_ff[1] & smp_ff[0]) | (smp_ff[1] & rx_in) | (smp_ff[0] & rx_in);
        noisy = !((smp_ff[1] == smp_ff[0]) && (smp_ff[0] == rx_in));
        msb = wide ? rx_data_ff[8] : rx_data_ff[7];
        perr = pon && (par_bit(rx_data_ff, wide, podd) != msb);
        idle_lim = {frame_len(wide), 4'h0};
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rx_state_ff <= RX_IDLE;
            phase_ff <= 4'h0;
            idx_ff <= 4'h0;
            smp_ff <= 2'b11;
            prev_ff <= 1'b1;
            noise_ff <= 1'b0;
            idle_arm_ff <= 1'b1;
            rx_data_ff <= 9'h000;
            rdr_ff <= 9'h000;
            idle_cnt_ff <= 8'h00;
            raf_ff <= 1'b0;
            rx_ev_ff <= 9'h000;
            wake_ev_ff <= 1'b0;
        end else begin
            rx_ev_ff <= 9'h000;
            wake_ev_ff <= 1'b0;
            if (!rx_on) begin
                rx_state_ff <= RX_IDLE;
                raf_ff <= 1'b0;
                idle_cnt_ff <= 8'h00;
            end else if (bif.sample_tick) begin
                prev_ff <= rx_in;
                if (!rx_in) begin
                    idle_cnt_ff <= 8'h00;
                end else if ((!ctrl_ff[`ILT_BIT] || rx_state_ff == RX_IDLE)
                    && idle_cnt_ff != idle_lim) begin
                    idle_cnt_ff <= idle_cnt_ff + 8'h01;
                    if (idle_cnt_ff == idle_lim - 8'h01) begin
                        raf_ff <= 1'b0;
                        if (sleep && !ctrl_ff[`WAKE_BIT]) begin
                            wake_ev_ff <= 1'b1;
                        end else if (!sleep && idle_arm_ff) begin
                            rx_ev_ff[`IDLE_BIT] <= 1'b1;
                            idle_arm_ff <= 1'b0;
                        end
                    end
                end
                case (rx_state_ff)
                    RX_IDLE: begin
                        if (prev_ff && !rx_in) begin
                            rx_state_ff <= RX_BITS;
                            phase_ff <= `RESYNC_PH;
                            idx_ff <= 4'h0;
                            noise_ff <= 1'b0;
                            raf_ff <= 1'b1;
                        end
                    end
                    RX_BITS: begin
                        phase_ff <= phase_ff + 4'h1;
                        if (phase_ff == `SMP_A || phase_ff == `SMP_B) begin
                            smp_ff <= {smp_ff[0], rx_in};
                        end else if (phase_ff == `SMP_C) begin
                            if (idx_ff == 4'h0) begin
                                if (maj) begin
                                    rx_state_ff <= RX_IDLE;
                                end else begin
                                    noise_ff <= noisy;
                                    idx_ff <= 4'h1;
                                end
                            end else if (idx_ff != frame_len(wide) - 4'h1) begin
                                rx_data_ff[idx_ff - 4'h1] <= maj;
                                noise_ff <= noise_ff | noisy;
                                idx_ff <= idx_ff + 4'h1;
                            end else begin
                                rx_state_ff <= RX_IDLE;
                                if (!sleep || (ctrl_ff[`WAKE_BIT] && msb)) begin
                                    wake_ev_ff <= sleep;
                                    if (flag_ff[`OR_BIT]) begin
                                        rx_ev_ff <= 9'h000;
                                    end else if (flag_ff[`RX_HOLDING_FULL_BIT]) begin
                                        rx_ev_ff[`OR_BIT] <= 1'b1;
                                    end else begin
                                        rdr_ff <= wide ? rx_data_ff : {1'b0, rx_data_ff[7:0]};
                                        rx_ev_ff[`RX_HOLDING_FULL_BIT] <= 1'b1;
                                        rx_ev_ff[`NF_BIT] <= noise_ff | noisy;
                                        rx_ev_ff[`FE_BIT] <= !maj;
                                        rx_ev_ff[`PF_BIT] <= perr;
                                        idle_arm_ff <= 1'b1;
                                    end
                                end
                            end
                        end else if (rx_in != prev_ff) begin
                            phase_ff <= `RESYNC_PH;
                        end
                    end
                    default: begin
                        rx_state_ff <= RX_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : async_serial_interface

// ### logic/baud_gen.sv
// modulus counter giving 16x sample ticks and bit ticks
// assumes the divisor comes from a register on the same clock
module baud_gen #(parameter int DIV_W = 13) (
    input wire logic i_clk,
    input wire logic i_resetn,
    baud_if.gen bus
);
    import async_serial_pkg::*;
    logic [DIV_W:0] cnt_ff;
    logic [3:0] sub_ff;
    logic smp_ff;
    logic bit_ff;

    assign bus.sample_tick = smp_ff;
    assign bus.bit_tick = bit_ff;

    // ************
    // two clocks per divisor step per sample
    // ************
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_ff <= '0;
            sub_ff <= 4'h0;
            smp_ff <= 1'b0;
            bit_ff <= 1'b0;
        end else begin
            smp_ff <= 1'b0;
            bit_ff <= 1'b0;
            if (bus.divisor == '0) begin
                cnt_ff <= '0;
                sub_ff <= 4'h0;
            end else if (cnt_ff >= ({bus.divisor, 1'b0} - 1'b1)) begin
                cnt_ff <= '0;
                smp_ff <= 1'b1;
                sub_ff <= sub_ff + 4'h1;
                if (sub_ff == 4'hF) begin
                    bit_ff <= 1'b1;
                end
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule : baud_gen

// ### tb/async_serial_interface_sva.sv
// concurrent checks on the serial unit's top ports
// assumes control and divisor change only through register port writes
`include "async_serial_defs.svh"
module async_serial_interface_sva #(parameter int DIV_W = 13) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input async_serial_pkg::addr_type I_ADDR,
    input async_serial_pkg::word_type I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input async_serial_pkg::word_type O_RDATA,
    input wire logic O_TXD,
    input wire logic O_TXD_OE,
    input wire logic O_IRQ
);
    import async_serial_pkg::*;
    logic [14:0] ctrl_ff;
    logic [DIV_W-1:0] div_ff;
    logic [1:0] quiet_ff;
    // ************
    // shadows of written registers
    // ************
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl_ff <= 15'h0000;
            div_ff <= DIV_W'(0);
        end else if (I_WR && I_ADDR == `CTRL_OFS) begin
            ctrl_ff <= I_WDATA[14:0];
        end else if (I_WR && I_ADDR == `BAUD_OFS) begin
            div_ff <= I_WDATA[DIV_W-1:0];
        end
    end
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN || div_ff != DIV_W'(0) || !ctrl_ff[3]) begin
            quiet_ff <= 2'h0;
        end else if (quiet_ff != 2'h3) begin
            quiet_ff <= quiet_ff + 2'h1;
        end
    end
    // ************
    // checks
    // ************
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);
    chk_baud_readback: assert property ($past(I_RD) && $past(I_ADDR) == `BAUD_OFS
        |-> O_RDATA == 16'($past(div_ff))) else $error("baud readback differs from last write");
    chk_status_upper: assert property ($past(I_RD) && $past(I_ADDR) == `STAT_OFS
        |-> O_RDATA[15:9] == 7'h00) else $error("status upper bits not zero");
    chk_stopped_line: assert property (quiet_ff == 2'h3 |-> $stable(O_TXD))
        else $error("line moved with divisor zero");
    chk_bit_length: assert property ($changed(O_TXD) && ctrl_ff[3] && div_ff == DIV_W'(1)
        |=> $stable(O_TXD) [*8]) else $error("bit shorter than expected");
    chk_irq_masked: assert property (ctrl_ff[7:4] == 4'h0 && $past(ctrl_ff[7:4]) == 4'h0
        |-> !O_IRQ) else $error("request with all enables off");
    chk_open_drain: assert property (ctrl_ff[13] && $past(ctrl_ff[13])
        |-> !(O_TXD_OE && O_TXD)) else $error("open drain pin driven high");
    chk_loop_mark: assert property (ctrl_ff[14] && ctrl_ff[3] && $past(ctrl_ff[14])
        |-> O_TXD) else $error("pin not at mark in loopback");
    chk_tx_hold: assert property ($fell(ctrl_ff[3]) && !O_TXD && !ctrl_ff[13]
        |-> O_TXD_OE [*8]) else $error("pin released mid character");
    chk_tx_idle: assert property ($rose(ctrl_ff[3]) && !ctrl_ff[13]
        |-> ##2 O_TXD && O_TXD_OE) else $error("line not idle high after enable");
    cover property (O_IRQ);
    cover property (ctrl_ff[14] && ctrl_ff[3]);
    cover property ($fell(ctrl_ff[3]) && !O_TXD);
endmodule : async_serial_interface_sva
bind async_serial_interface async_serial_interface_sva #(.DIV_W(DIV_W)) u_sva (
    .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA),
    .O_TXD(O_TXD), .O_TXD_OE(O_TXD_OE), .O_IRQ(O_IRQ));

// ### tb/async_serial_interface_tb_top.sv
// self-checking bench for the serial unit
// assumes the partner model on the pins and divisor 1, 32 clocks a bit
`include "async_serial_defs.svh"
module async_serial_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import async_serial_pkg::*;
    logic clk, resetn, wr_stb, rd_stb, rxd, gpio_dir, gpio_out, txd, txd_oe, irq;
    addr_type addr;
    word_type wdata, rdata, d, v;
    logic [7:0] frame;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed;
    async_serial_interface #(.DIV_W(13)) dut (.I_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_stb), .I_RD(rd_stb), .O_RDATA(rdata), .I_RXD(rxd), .I_GPIO_DIR(gpio_dir),
        .I_GPIO_OUT(gpio_out), .O_TXD(txd), .O_TXD_OE(txd_oe), .O_IRQ(irq));
    serial_partner #(.BIT_CLKS(32)) partner (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ************
    // helpers
    // ************
    function automatic logic par_bit(input logic [6:0] b);
        return ~^b;
    endfunction : par_bit
    function automatic word_type rx_flags(input logic bad, input logic stop);
        return {9'h000, 1'b1, 4'h0, ~stop, bad};
    endfunction : rx_flags
    task automatic check(input word_type seen, input word_type exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic bus_wr(input addr_type a, input word_type x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input addr_type a, output word_type x);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        x = rdata;
    endtask : bus_rd
    task automatic tx_byte(input word_type x);
        bus_rd(`STAT_OFS, d);
        bus_wr(`DATA_OFS, x);
    endtask : tx_byte
    task automatic wait_frame();
        int n0 = partner.n_frames;
        for (int k = 0; k < 2000 && partner.n_frames == n0; k++) begin
            @(posedge clk);
        end
    endtask : wait_frame
    task automatic rx_chk(input word_type e, input word_type m, input word_type f);
        settle(40);
        bus_rd(`STAT_OFS, d);
        check(d & 16'h004F, f);
        bus_rd(`DATA_OFS, d);
        check(d & m, e);
        bus_rd(`STAT_OFS, d);
        check(d & 16'h0048, 16'h0000);
    endtask : rx_chk
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // ************
    // main sequence
    // ************
    initial begin
        seed = 32'h194A;
        resetn = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        gpio_dir = 1'b1;
        gpio_out = 1'b1;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        bus_rd(`STAT_OFS, d);
        check(d, 16'h0180);
        bus_rd(4'h0, d);
        check(d, 16'h0000);
        bus_wr(`CTRL_OFS, 16'h000C);
        settle(40);
        check(txd, 1'b1);
        bus_wr(`CTRL_OFS, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 16'hFFFF : 16'($random(seed));
            bus_wr(`BAUD_OFS, v);
            bus_rd(`BAUD_OFS, d);
            check(d, v & 16'h1FFF);
        end
        bus_wr(`BAUD_OFS, 16'h0001);
        bus_wr(`CTRL_OFS, 16'h000C);
        settle(400);
        v = 16'($random(seed)) & 16'h00FF;
        tx_byte(v);
        wait_frame();
        check(partner.got_ff, {1'b1, v[7:0]});
        settle(40);
        bus_rd(`STAT_OFS, d);
        check(d & 16'h0180, 16'h0180);
        v = 16'($random(seed)) & 16'h00FF;
        partner.send(v[8:0], 8, 1'b1);
        rx_chk(v, 16'h01FF, 16'h0040);
        bus_wr(`CTRL_OFS, 16'h0C0C);
        for (int i = 0; i < 3; i++) begin
            frame = 8'($random(seed));
            frame[7] = par_bit(frame[6:0]) ^ (i == 1);
            partner.send({1'b0, frame}, 8, i != 2);
            rx_chk({9'h000, frame[6:0]}, 16'h007F, rx_flags(i == 1, i != 2));
        end
        bus_wr(`CTRL_OFS, 16'h002C);
        v = 16'($random(seed)) & 16'h00FF;
        partner.send(v[8:0], 8, 1'b1);
        settle(40);
        check(irq, 1'b1);
        partner.send(~v[8:0], 8, 1'b1);
        bus_wr(`CTRL_OFS, 16'h000C);
        settle(3);
        check(irq, 1'b0);
        rx_chk(v, 16'h01FF, 16'h0048);
        bus_wr(`CTRL_OFS, 16'h400C);
        v = 16'($random(seed)) & 16'h00FF;
        tx_byte(v);
        settle(400);
        rx_chk(v, 16'h01FF, 16'h0040);
        bus_wr(`CTRL_OFS, 16'h000D);
        wait_frame();
        check(partner.got_ff, 16'h0000);
        bus_wr(`CTRL_OFS, 16'h000C);
        settle(400);
        tx_byte(16'h0000);
        settle(100);
        bus_wr(`CTRL_OFS, 16'h0000);
        settle(2);
        check({txd_oe, txd}, 2'b10);
        settle(400);
        gpio_dir <= 1'b0;
        settle(3);
        check(txd_oe, 1'b0);
        gpio_dir <= 1'b1;
        bus_wr(`CTRL_OFS, 16'h2000);
        settle(3);
        check(txd_oe, 1'b0);
        gpio_out <= 1'b0;
        settle(3);
        check({txd_oe, txd}, 2'b10);
        stop_test();
    end
endmodule : async_serial_interface_tb_top

// ### tb/serial_partner.sv
// far-end serial device: drives the receive pin, captures transmit frames
// assumes idle-high lines and BIT_CLKS clocks a bit
module serial_partner #(parameter int BIT_CLKS = 32) (
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] got_ff;
    int n_frames = 0;
    initial o_rxd = 1'b1;
    task automatic send(input logic [8:0] data, input int nbits, input logic stop);
        @(posedge i_clk);
        o_rxd <= 1'b0;
        repeat (BIT_CLKS) @(posedge i_clk);
        for (int i = 0; i < nbits; i++) begin
            o_rxd <= data[i];
            repeat (BIT_CLKS) @(posedge i_clk);
        end
        o_rxd <= stop;
        repeat (BIT_CLKS) @(posedge i_clk);
        o_rxd <= 1'b1;
    endtask : send
    always begin
        @(negedge i_txd);
        repeat (BIT_CLKS / 2) @(posedge i_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            got_ff[i] = i_txd;
        end
        n_frames++;
    end
endmodule : serial_partner
